/* File: rtl/bctr_pkg.sv */
// shared constants and carriers for the boot configuration block
package bctr_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // eeprom interrogation window, milliseconds
  localparam int unsigned EEPROM_WINDOW_MS = 250;
  localparam int unsigned EEPROM_WINDOW_CYC =
    (CLK_HZ / 1000) * EEPROM_WINDOW_MS;
  localparam int unsigned STRAP_SETTLE_CYC = 16;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned TXR_GPIO_NUM = 5;
  localparam int unsigned CNT_W = 16;
  localparam logic txr_en_reset = 1'b0;
  localparam logic [1:0] llc_rom_default = 2'h0;
  localparam logic [1:0] llc_recovery = 2'h3;
  localparam logic [1:0] src_none = 2'h0;
  localparam logic [1:0] src_backup_ram = 2'h1;
  localparam logic [1:0] src_eeprom = 2'h2;
  localparam logic [1:0] src_flash = 2'h3;

  typedef struct packed {
    logic clk;
    logic sel_n;
    logic mosi;
    logic miso;
  } bctr_spi_pins_t;

  typedef struct packed {
    logic enable;
    logic active_high;
    logic [15:0] threshold;
  } bctr_txr_cfg_t;
endpackage

/* File: rtl/bctr_sync.sv */
// three-stage synchroniser for pin inputs, agreement filtered
`timescale 1ns/1ps
module bctr_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_out;

  // output moves only once stage two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_out[i] = (s2[i] == s3[i]) ? s3[i] : o_sync[i];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      o_sync <= INIT;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      o_sync <= next_out;
    end
  end
endmodule

/* File: rtl/bctr_txready.sv */
// transmit-ready indicator with threshold and polarity
`timescale 1ns/1ps
module bctr_txready #(
  parameter int unsigned CW = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire bctr_pkg::bctr_txr_cfg_t i_cfg,
  input wire logic [CW-1:0] i_pending,
  output logic o_level,
  output logic o_active
);
  logic active;
  logic next_active;

  always_comb begin
    next_active = 1'b0;
    if (i_cfg.enable && (i_pending >= i_cfg.threshold[CW-1:0])) begin
      next_active = 1'b1; // RL3 RL20
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      active <= 1'b0;
      o_level <= 1'b0;
    end else begin
      active <= next_active;
      o_level <= next_active ~^ i_cfg.active_high; // RL3
    end
  end

  assign o_active = active;

  property p_txr_thresh;
    @(posedge i_clk) disable iff (i_reset)
      (i_cfg.enable && i_pending >= i_cfg.threshold[CW-1:0])
      |=> active;
  endproperty
  a_txr_thresh: assert property (p_txr_thresh) // RL3
    else $error("tx ready not raised at threshold");

  property p_txr_drop;
    @(posedge i_clk) disable iff (i_reset)
      (i_pending < i_cfg.threshold[CW-1:0]) |=> !active;
  endproperty
  a_txr_drop: assert property (p_txr_drop) // RL20
    else $error("tx ready held below threshold");
endmodule

/* File: rtl/bctr_top.sv */
// start-up configuration sequencer with tx ready and antenna off
//
// Behaviour
// [RL1] wake on uart or event input change
// [RL2] host holds spi clock strap low
// [RL3] tx ready polarity and threshold configurable
// [RL4] listener may watch tx ready instead
// [RL5] tx ready routable to gpio five
// [RL6] tx ready disabled after reset
// [RL7] recovery pin low: no navigation start
// [RL8] recovery mode ignores straps and memories; spi host select is still latched from the clock strap
// [RL9] low level, detect, then functional config
// [RL10] low level from rom or straps
// [RL11] functional from backup ram, eeprom or flash
// [RL12] runtime changes last until reset
// [RL13] saved settings persist per medium
// [RL14] capture straps before releasing spi pins
// [RL15] gpio usable as antenna power off
// [RL16] host may supply slow clock
// [RL17] antenna power off in power save
// [RL18] eeprom detect within 250 ms
// [RL19] flash present only if spi high
// [RL20] tx ready drops below threshold
`timescale 1ns/1ps
module bctr_top #(
  parameter int unsigned EEPROM_WINDOW_CYC = bctr_pkg::EEPROM_WINDOW_CYC,
  parameter int unsigned CW = bctr_pkg::CNT_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_recovery_boot_n,
  input wire logic i_config_strap_a,
  input wire logic i_config_strap_b,
  input wire logic i_shared_spi_clock_strap,
  input wire logic i_spi_sel_n,
  input wire logic i_uart_receive_input,
  input wire logic i_external_event_input_a,
  input wire logic i_external_event_input_b,
  input wire logic i_eeprom_ack,
  input wire logic i_eeprom_ack_valid,
  input wire logic i_backup_ram_valid,
  input wire logic i_backup_supply_ok,
  input wire logic i_sleep_req,
  input wire logic i_power_save_off,
  input wire logic i_rt_cfg_we,
  input wire logic [1:0] i_rt_cfg_save,
  input wire bctr_pkg::bctr_txr_cfg_t i_rt_txr_cfg,
  input wire logic i_rt_txr_on_gpio,
  input wire logic i_rt_antenna_off_en,
  input wire logic i_uart_tx_data,
  input wire logic [CW-1:0] i_pending_bytes,
  output logic o_recovery_mode,
  output logic o_nav_start,
  output logic [1:0] o_low_level_cfg,
  output logic o_spi_host_sel,
  output logic o_spi_released,
  output logic o_eeprom_probe,
  output logic o_eeprom_bus_free,
  output logic [1:0] o_func_src,
  output logic o_config_done,
  output logic o_asleep,
  output logic [1:0] o_save_req,
  output logic o_uart_transmit_output,
  output logic o_tx_ready_active,
  output logic o_antenna_off_pin,
  output logic o_antenna_off_oe
);
  localparam int unsigned STRAP_CYC = bctr_pkg::STRAP_SETTLE_CYC;

  typedef enum logic [2:0] {
    ST_STRAP, ST_LOWLVL, ST_DETECT, ST_FUNC, ST_RUN, ST_SLEEP
  } bctr_state_t;

  // pin inputs synchronised; all idle high by pull-ups
  logic [7:0] pins_raw;
  logic [7:0] pins;
  assign pins_raw = {i_recovery_boot_n, i_config_strap_a,
                     i_config_strap_b, i_shared_spi_clock_strap,
                     i_spi_sel_n, i_uart_receive_input,
                     i_external_event_input_a, i_external_event_input_b};

  bctr_sync #(.WIDTH(8), .INIT(8'hff)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  bctr_pkg::bctr_spi_pins_t spi;
  assign spi = '{clk: pins[4], sel_n: pins[3], mosi: pins[6],
                 miso: pins[5]};

  bctr_state_t state;
  bctr_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic recovery;
  logic next_recovery;
  logic [1:0] llc;
  logic [1:0] next_llc;
  logic spi_host;
  logic next_spi_host;
  logic flash_ok;
  logic next_flash_ok;
  logic eeprom_ok;
  logic next_eeprom_ok;
  logic [1:0] src;
  logic [1:0] next_src;
  logic [2:0] wake_prev;
  logic [2:0] next_wake_prev;
  bctr_pkg::bctr_txr_cfg_t txr_cfg;
  bctr_pkg::bctr_txr_cfg_t next_txr_cfg;
  logic txr_on_gpio;
  logic next_txr_on_gpio;
  logic antenna_off_en;
  logic next_antenna_off_en;
  logic [1:0] save;
  logic [1:0] next_save;
  logic wake_evt;

  // any level change on the three wake inputs
  assign wake_evt = |(wake_prev ^ pins[2:0]); // RL1

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_recovery = recovery;
    next_llc = llc;
    next_spi_host = spi_host;
    next_flash_ok = flash_ok;
    next_eeprom_ok = eeprom_ok;
    next_src = src;
    next_wake_prev = pins[2:0];
    next_txr_cfg = txr_cfg;
    next_txr_on_gpio = txr_on_gpio;
    next_antenna_off_en = antenna_off_en;
    next_save = 2'h0;
    case (state)
      ST_STRAP: begin
        // wait for synchronisers to settle before sampling straps
        next_cnt = cnt + 32'h1;
        if (cnt == 32'(STRAP_CYC - 1)) begin
          next_cnt = '0;
          next_recovery = !pins[7]; // RL7
          next_spi_host = !pins[4]; // RL2
          // data straps must be latched before the spi pins are let go
          next_llc = {pins[6], pins[5]}; // RL10 RL14
          next_state = ST_LOWLVL; // RL14
        end
      end
      ST_LOWLVL: begin
        if (recovery) begin
          next_llc = bctr_pkg::llc_recovery; // RL8
          next_state = ST_RUN; // RL8
        end else begin
          next_state = ST_DETECT; // RL9
        end
      end
      ST_DETECT: begin
        next_flash_ok = spi.clk & spi.sel_n & spi.mosi & spi.miso; // RL19
        next_cnt = cnt + 32'h1;
        if (i_eeprom_ack_valid) begin
          next_eeprom_ok = i_eeprom_ack;
        end
        // bounded probe window; bus released at its end
        if (cnt == 32'(EEPROM_WINDOW_CYC - 1)) begin // RL18
          next_state = ST_FUNC; // RL9
        end
      end
      ST_FUNC: begin
        if (eeprom_ok) begin
          next_src = bctr_pkg::src_eeprom; // RL11
        end else if (flash_ok) begin
          next_src = bctr_pkg::src_flash; // RL11
        end else if (i_backup_ram_valid && i_backup_supply_ok) begin
          next_src = bctr_pkg::src_backup_ram; // RL13
        end else begin
          next_src = bctr_pkg::src_none;
        end
        next_state = ST_RUN;
      end
      ST_RUN: begin
        // runtime changes live in flops until reset
        if (i_rt_cfg_we) begin
          next_txr_cfg = i_rt_txr_cfg; // RL12
          next_txr_on_gpio = i_rt_txr_on_gpio; // RL5
          next_antenna_off_en = i_rt_antenna_off_en; // RL15
          next_save = i_rt_cfg_save; // RL13
        end
        if (i_sleep_req) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          next_state = ST_RUN; // RL1
        end
      end
      default: next_state = ST_STRAP;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_STRAP;
      cnt <= '0;
      recovery <= 1'b0;
      llc <= bctr_pkg::llc_rom_default;
      spi_host <= 1'b0;
      flash_ok <= 1'b0;
      eeprom_ok <= 1'b0;
      src <= bctr_pkg::src_none;
      wake_prev <= 3'h7;
      txr_cfg <= '{enable: bctr_pkg::txr_en_reset, active_high: 1'b1,
                   threshold: 16'h0001}; // RL6
      txr_on_gpio <= 1'b0;
      antenna_off_en <= 1'b0;
      save <= 2'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      recovery <= next_recovery;
      llc <= next_llc;
      spi_host <= next_spi_host;
      flash_ok <= next_flash_ok;
      eeprom_ok <= next_eeprom_ok;
      src <= next_src;
      wake_prev <= next_wake_prev;
      txr_cfg <= next_txr_cfg;
      txr_on_gpio <= next_txr_on_gpio;
      antenna_off_en <= next_antenna_off_en;
      save <= next_save;
    end
  end

  logic txr_level;
  logic txr_active;

  bctr_txready #(.CW(CW)) u_txr (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_cfg(txr_cfg),
    .i_pending(i_pending_bytes),
    .o_level(txr_level),
    .o_active(txr_active)
  );

  logic gpio_out;
  logic next_gpio_out;
  logic ant_off;
  logic next_ant_off;

  always_comb begin
    next_gpio_out = txr_on_gpio ? txr_level : i_uart_tx_data; // RL5
    // antenna off while asleep or in power-save stage
    next_ant_off = antenna_off_en &&
      (state == ST_SLEEP || i_power_save_off); // RL17
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gpio_out <= 1'b1;
      ant_off <= 1'b0;
    end else begin
      gpio_out <= next_gpio_out;
      ant_off <= next_ant_off;
    end
  end

  assign o_uart_transmit_output = gpio_out;
  assign o_tx_ready_active = txr_active;
  assign o_antenna_off_pin = ant_off; // RL15
  assign o_antenna_off_oe = antenna_off_en;
  assign o_recovery_mode = recovery;
  assign o_nav_start = (state == ST_RUN || state == ST_SLEEP) && !recovery;
  assign o_low_level_cfg = llc;
  assign o_spi_host_sel = spi_host;
  assign o_spi_released = (state != ST_STRAP);
  assign o_eeprom_probe = (state == ST_DETECT);
  assign o_eeprom_bus_free = (state == ST_FUNC || state == ST_RUN ||
                              state == ST_SLEEP);
  assign o_func_src = src;
  assign o_config_done = (state == ST_RUN);
  assign o_asleep = (state == ST_SLEEP);
  assign o_save_req = save;

  property p_no_nav_recovery;
    @(posedge i_clk) disable iff (i_reset) recovery |-> !o_nav_start;
  endproperty
  a_no_nav_recovery: assert property (p_no_nav_recovery) // RL7
    else $error("navigation started in recovery");

  property p_recovery_fixed;
    @(posedge i_clk) disable iff (i_reset)
      (state == ST_LOWLVL && recovery) |=>
        (llc == bctr_pkg::llc_recovery && state == ST_RUN);
  endproperty
  a_recovery_fixed: assert property (p_recovery_fixed) // RL8
    else $error("recovery config not fixed");

  sequence s_lowlvl;
    state == ST_LOWLVL && !recovery;
  endsequence
  sequence s_detect_then;
    state == ST_DETECT;
  endsequence
  property p_order;
    @(posedge i_clk) disable iff (i_reset) s_lowlvl |=> s_detect_then;
  endproperty
  a_order: assert property (p_order) // RL9
    else $error("detection did not follow low level");

  property p_flash_detect;
    @(posedge i_clk) disable iff (i_reset)
      (state == ST_DETECT && !(spi.clk && spi.sel_n && spi.mosi &&
       spi.miso)) |=> !flash_ok;
  endproperty
  a_flash_detect: assert property (p_flash_detect) // RL19
    else $error("flash seen with a low spi pin");

  property p_release;
    @(posedge i_clk) disable iff (i_reset)
      o_spi_released && !$past(o_spi_released) |-> $changed(state);
  endproperty
  a_release: assert property (p_release) // RL14
    else $error("spi released outside strap capture");

  property p_wake;
    @(posedge i_clk) disable iff (i_reset)
      (state == ST_SLEEP && wake_evt) |=> state == ST_RUN;
  endproperty
  a_wake: assert property (p_wake) // RL1
    else $error("no wake on input change");

  property p_detect_bound;
    @(posedge i_clk) disable iff (i_reset)
      state == ST_DETECT |-> cnt < 32'(EEPROM_WINDOW_CYC);
  endproperty
  a_detect_bound: assert property (p_detect_bound) // RL18
    else $error("eeprom probe overran window");

  property p_gpio_route;
    @(posedge i_clk) disable iff (i_reset)
      txr_on_gpio |=> o_uart_transmit_output == $past(txr_level);
  endproperty
  a_gpio_route: assert property (p_gpio_route) // RL5
    else $error("tx ready not on gpio");

  property p_antenna_off;
    @(posedge i_clk) disable iff (i_reset)
      (antenna_off_en && i_power_save_off) |=> o_antenna_off_pin;
  endproperty
  a_antenna_off: assert property (p_antenna_off) // RL17
    else $error("antenna not switched off");
endmodule

/* File: dv/bctr_host_model.sv */
// host-side pin model: boot straps, spi lines and eeprom probe answers
`timescale 1ns/1ps
module bctr_host_model (
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  input wire logic i_spi_released,
  input wire logic i_eeprom_probe,
  output logic o_clk_strap,
  output logic o_sel_n,
  output logic o_strap_a,
  output logic o_strap_b,
  output logic o_ack,
  output logic o_ack_valid
);
  // modes: 0 spi host, 1 serial flash, 2 eeprom, 3 bare board
  logic flip = 1'b0;
  always @(negedge i_clk) begin
    flip <= ~flip;
    o_clk_strap <= (i_mode == 2'h1);
    o_sel_n <= (i_mode != 2'h3);
    if (i_spi_released && i_mode != 2'h1) begin
      // released data lines must not hold a stale strap level
      o_strap_a <= flip;
      o_strap_b <= ~flip;
    end else begin
      o_strap_a <= 1'b1;
      o_strap_b <= (i_mode == 2'h1);
    end
    // answers only inside interrogation; host stays off the bus until then
    o_ack_valid <= i_eeprom_probe && i_mode == 2'h2;
    o_ack <= i_eeprom_probe && i_mode == 2'h2;
  end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the boot configuration sequencer
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic en;
    logic ah;
    logic gpio;
    logic [15:0] thr;
    logic [15:0] pend;
    logic act;
  } bctr_tb_row_t;
  localparam int unsigned WIN = 50;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic rec_n = 1'b1, uart_rx = 1'b1, ev_a = 1'b0, ev_b = 1'b0;
  logic ram_ok = 1'b0, sup_ok = 1'b0, sleep_req = 1'b0, ps_off = 1'b0;
  logic we = 1'b0, gpio_on = 1'b0, ant_en = 1'b0, tx_data = 1'b1;
  logic [1:0] save = 2'h0;
  logic [1:0] mode = 2'h0;
  logic [15:0] pend = 16'h0000;
  bctr_pkg::bctr_txr_cfg_t cfg = '0;
  logic clk_strap, sel_n, strap_a, strap_b, ack, ack_v;
  logic rec_m, nav, host_sel, released, probe, bus_free, done, asleep;
  logic tx_pin, txr_act, ant_pin, ant_oe;
  logic [1:0] llc, src, save_req;
  int fail_count = 0;
  int compares = 0;
  bctr_tb_row_t rows [8];

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  bctr_host_model host (.i_clk(i_clk), .i_mode(mode),
    .i_spi_released(released), .i_eeprom_probe(probe),
    .o_clk_strap(clk_strap), .o_sel_n(sel_n), .o_strap_a(strap_a),
    .o_strap_b(strap_b), .o_ack(ack), .o_ack_valid(ack_v));

  bctr_top #(.EEPROM_WINDOW_CYC(WIN), .CW(16)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_recovery_boot_n(rec_n),
    .i_config_strap_a(strap_a), .i_config_strap_b(strap_b),
    .i_shared_spi_clock_strap(clk_strap), .i_spi_sel_n(sel_n),
    .i_uart_receive_input(uart_rx), .i_external_event_input_a(ev_a),
    .i_external_event_input_b(ev_b), .i_eeprom_ack(ack),
    .i_eeprom_ack_valid(ack_v), .i_backup_ram_valid(ram_ok),
    .i_backup_supply_ok(sup_ok), .i_sleep_req(sleep_req),
    .i_power_save_off(ps_off), .i_rt_cfg_we(we), .i_rt_cfg_save(save),
    .i_rt_txr_cfg(cfg), .i_rt_txr_on_gpio(gpio_on),
    .i_rt_antenna_off_en(ant_en), .i_uart_tx_data(tx_data),
    .i_pending_bytes(pend), .o_recovery_mode(rec_m), .o_nav_start(nav),
    .o_low_level_cfg(llc), .o_spi_host_sel(host_sel),
    .o_spi_released(released), .o_eeprom_probe(probe),
    .o_eeprom_bus_free(bus_free), .o_func_src(src),
    .o_config_done(done), .o_asleep(asleep), .o_save_req(save_req),
    .o_uart_transmit_output(tx_pin), .o_tx_ready_active(txr_act),
    .o_antenna_off_pin(ant_pin), .o_antenna_off_oe(ant_oe));

  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic rt(input bctr_pkg::bctr_txr_cfg_t c, input logic g,
                    input logic a, input logic [1:0] s);
    cfg = c;
    gpio_on = g;
    ant_en = a;
    save = s;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
  endtask

  // full start-up; probe cycles counted to bound the interrogation
  task automatic boot(input logic [1:0] m, input logic r,
                      input logic [1:0] es);
    int pc;
    mode = m;
    rec_n = r;
    i_reset = 1'b1;
    cyc(20);
    chk("tx_pin_reset", 1'b1, tx_pin);
    chk("ant_oe_reset", 1'b0, ant_oe);
    i_reset = 1'b0;
    pc = 0;
    cyc(8);
    chk("spi_released_early", 1'b0, released);
    for (int k = 0; k < 300 && done !== 1'b1; k++) begin
      cyc(1);
      if (probe === 1'b1) pc++;
    end
    chk("config_done", 1'b1, done);
    chk("recovery_mode", !r, rec_m);
    chk("nav_start", r, nav);
    chk("func_src", es, src);
    chk("probe_window", r, pc > 0 && pc <= WIN);
    chk("tx_ready_off", 1'b0, txr_act);
    if (r) chk("spi_host_sel", m != 2'h1, host_sel);
    if (r) chk("bus_free", 1'b1, bus_free);
    if (!r) chk("llc_fixed", bctr_pkg::llc_recovery, llc);
    if (r) chk("llc_straps", {1'b1, m == 2'h1}, llc);
  endtask

  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end

  initial begin
    bctr_pkg::bctr_txr_cfg_t c;
    logic exp_pin;
    rows = '{'{1'b1, 1'b1, 1'b1, 16'h0004, 16'h0003, 1'b0},
             '{1'b1, 1'b1, 1'b1, 16'h0004, 16'h0004, 1'b1},
             '{1'b1, 1'b1, 1'b1, 16'h0004, 16'h0003, 1'b0},
             '{1'b1, 1'b0, 1'b1, 16'h0004, 16'h0005, 1'b1},
             '{1'b1, 1'b0, 1'b1, 16'h0004, 16'h0000, 1'b0},
             '{1'b1, 1'b1, 1'b0, 16'h0001, 16'h0001, 1'b1},
             '{1'b1, 1'b1, 1'b1, 16'hffff, 16'hfffe, 1'b0},
             '{1'b0, 1'b1, 1'b1, 16'h0001, 16'h0009, 1'b0}};
    boot(2'h0, 1'b1, bctr_pkg::src_none);
    for (int i = 0; i < 8; i++) begin
      c = '{rows[i].en, rows[i].ah, rows[i].thr};
      pend = rows[i].pend;
      rt(c, rows[i].gpio, 1'b0, 2'h0);
      cyc(3);
      chk("tx_ready_active", rows[i].act, txr_act);
      // routed pin shows the indicator level even while it is disabled
      exp_pin = rows[i].gpio ? (rows[i].act == rows[i].ah) : tx_data;
      chk("gpio05", exp_pin, tx_pin);
    end
    for (int s = 1; s < 4; s++) begin
      rt(cfg, 1'b0, 1'b1, s[1:0]);
      chk("save_req", s[1:0], save_req);
      cyc(1);
      chk("save_req_end", 2'h0, save_req);
    end
    chk("ant_oe", 1'b1, ant_oe);
    chk("ant_pin_run", 1'b0, ant_pin);
    ps_off = 1'b1;
    cyc(3);
    chk("ant_pin_ps", 1'b1, ant_pin);
    ps_off = 1'b0;
    // each wake source in turn; a refused write while asleep
    for (int w = 0; w < 3; w++) begin
      sleep_req = 1'b1;
      cyc(3);
      sleep_req = 1'b0;
      chk("asleep", 1'b1, asleep);
      chk("ant_pin_sleep", 1'b1, ant_pin);
      rt(cfg, 1'b0, 1'b1, 2'h1);
      chk("save_refused", 2'h0, save_req);
      cyc(10);
      chk("still_asleep", 1'b1, asleep);
      if (w == 0) uart_rx = ~uart_rx;
      else if (w == 1) ev_a = ~ev_a;
      else ev_b = ~ev_b;
      cyc(8);
      chk("woken", 1'b0, asleep);
    end
    ram_ok = 1'b1;
    boot(2'h0, 1'b1, bctr_pkg::src_none);
    sup_ok = 1'b1;
    boot(2'h0, 1'b1, bctr_pkg::src_backup_ram);
    boot(2'h1, 1'b1, bctr_pkg::src_flash);
    boot(2'h2, 1'b1, bctr_pkg::src_eeprom);
    boot(2'h2, 1'b0, bctr_pkg::src_none);
    report_and_stop;
  end
endmodule
